//--- afo_defines.svh
// Constants for the alarm and frequency output channel
`ifndef AFO_DEFINES_SVH
`define AFO_DEFINES_SVH

`define AFO_VAL_W 24
`define AFO_SIG_ONE 24'sh000100
`define AFO_SIG_HALF 24'sh000080
`define AFO_CLK_PERIOD_NS 10
`define AFO_CLK_HZ 100000000
`define AFO_MS_NS 1000000
`define AFO_LOSS_TIMEOUT_DEF_MS 16'h0bb8
`define AFO_FLASH_HALF_MS 9'h1f4
`define AFO_FREQ_MAX_HZ 8'hc8
`define AFO_MHZ_PER_HZ 18'h003e8
`define AFO_FREQ_MAX_MHZ 18'h30d40
`define AFO_PERIOD_MAX_S 60
`define AFO_FREQ_MIN_MHZ 18'((1000 + `AFO_PERIOD_MAX_S - 1) / `AFO_PERIOD_MAX_S)
`define AFO_NCO_HALF 36'(64'd100000000 * 64'd1000 / 64'd2)
`define AFO_DIV_BITS 6'h2b

`endif

//--- afo_pkg.sv
// Types of the alarm and frequency output channel
package afo_pkg;
	typedef enum logic {AFO_FUNC_ALARM, AFO_FUNC_FREQ} afo_func_e;
	typedef enum logic [1:0] {AFO_SRC_FLOW, AFO_SRC_POWER, AFO_SRC_SIGNAL} afo_src_e;
	typedef enum logic {AFO_DIR_RISING, AFO_DIR_FALLING} afo_dir_e;
	typedef enum logic [1:0] {AFO_DIV_LOAD, AFO_DIV_RUN, AFO_DIV_DONE} afo_div_e;
	typedef logic signed [23:0] afo_val_t;
endpackage : afo_pkg

//--- afo_freq_gen.sv
// Square-wave generator driven by a frequency in millihertz
`timescale 1ns/1ps
`include "afo_defines.svh"
module afo_freq_gen (
	input logic clk,
	input logic rstn,
	input logic en,
	input logic [17:0] freqMilliHz,
	output logic waveOut
);
	logic [35:0] acc_ff;
	logic [35:0] nxt_acc;
	logic wave_ff;
	logic nxt_wave;
	logic [35:0] sum;

	// ****************************************
	// Phase accumulator, exact on average
	// ****************************************
	always_comb begin
		sum = acc_ff + 36'(freqMilliHz);
		nxt_acc = sum;
		nxt_wave = wave_ff;
		if (freqMilliHz == 18'h0) begin
			nxt_acc = 36'h0; // [R11]
			nxt_wave = 1'b1; // [R11]
		end else if (sum >= `AFO_NCO_HALF) begin
			nxt_acc = sum - `AFO_NCO_HALF; // [R13]
			nxt_wave = ~wave_ff;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			acc_ff <= 36'h0;
			wave_ff <= 1'b1;
		end else if (en) begin
			acc_ff <= nxt_acc;
			wave_ff <= nxt_wave;
		end
	end

	assign waveOut = wave_ff;

	zero_closed_a: assert property (@(posedge clk) disable iff (!rstn) // [R11]
		en && freqMilliHz == 18'h0 |=> waveOut)
		else $error("zero frequency did not close the switch");
endmodule : afo_freq_gen

//--- afo_channel.sv
// One digital output channel: hysteresis alarm or frequency output
// What this block does
// [R01] Rising flow alarm sets once flow exceeds the activation level.
// [R02] Rising alarm stays set until value drops below the deactivation level.
// [R03] Falling alarm sets below activation, clears above deactivation.
// [R04] Software keeps deactivation on the released side of activation.
// [R05] All threshold comparisons are signed.
// [R06] Power source uses the same hysteresis with power thresholds.
// [R07] Signal lost only after bad reception outlasts the timeout, default 3 s; reset instead loads lost_ff to 1 at once.
// [R08] Signal source value is 0 when lost, 1 otherwise.
// [R09] Signal source forces falling direction and both levels to 0.5.
// [R10] Frequency mode maps value linearly between two points, 0 to 200 Hz.
// [R11] Zero frequency holds the output switch closed.
// [R12] Period never exceeds 60 s; slower non-zero rates are raised.
// [R13] Average output frequency within one percent of target.
// [R14] Inverted frequency range is allowed.
// [R15] Alarm activation raises a status event and flashes the indicator.
// [R16] One function at a time; configuration sampled for the next comparison.
// [R17] Between levels the alarm state holds; reset clears it.
`timescale 1ns/1ps
`include "afo_defines.svh"
module afo_channel #(
	parameter int MS_CYCLES = `AFO_MS_NS / `AFO_CLK_PERIOD_NS
) (
	input logic ref_clk,
	input logic rstn,
	input logic clkEn,
	input afo_pkg::afo_func_e funcSel,
	input afo_pkg::afo_src_e srcSel,
	input afo_pkg::afo_dir_e dirSel,
	input afo_pkg::afo_val_t flowVal,
	input afo_pkg::afo_val_t powerVal,
	input afo_pkg::afo_val_t flowAct,
	input afo_pkg::afo_val_t flowDeact,
	input afo_pkg::afo_val_t powerAct,
	input afo_pkg::afo_val_t powerDeact,
	input logic sigBad,
	input logic [15:0] lossTimeoutMs,
	input logic [7:0] freqLoHz,
	input logic [7:0] freqHiHz,
	input afo_pkg::afo_val_t valLo,
	input afo_pkg::afo_val_t valHi,
	output logic outSwitch,
	output logic alarmActive,
	output logic alarmEvent,
	output logic ledFlash,
	output logic sigLost,
	output logic [17:0] freqMilliHz
);
	import afo_pkg::*;

	// ****************************************
	// Reset release
	// ****************************************
	logic [1:0] rstSync_ff;
	logic rstSyncN;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rstSync_ff <= 2'b00;
		end else begin
			rstSync_ff <= {rstSync_ff[0], 1'b1};
		end
	end
	assign rstSyncN = rstSync_ff[1];

	// ****************************************
	// Millisecond tick, signal loss and flash timing
	// ****************************************
	logic [16:0] msCnt_ff, nxt_msCnt;
	logic [15:0] lossCnt_ff, nxt_lossCnt;
	logic lost_ff, nxt_lost;
	logic [8:0] flashCnt_ff, nxt_flashCnt;
	logic flash_ff, nxt_flash;
	logic msTick;
	logic [15:0] tmo;
	logic alarm_ff;

	always_comb begin
		msTick = (msCnt_ff == 17'(MS_CYCLES - 1));
		nxt_msCnt = msTick ? 17'h0 : msCnt_ff + 17'h1;
		tmo = (lossTimeoutMs == 16'h0) ? `AFO_LOSS_TIMEOUT_DEF_MS : lossTimeoutMs; // [R07]
		nxt_lossCnt = lossCnt_ff;
		nxt_lost = lost_ff;
		if (!sigBad) begin
			nxt_lossCnt = 16'h0;
			nxt_lost = 1'b0;
		end else if (msTick) begin
			if (lossCnt_ff != 16'hffff) begin
				nxt_lossCnt = lossCnt_ff + 16'h1;
			end
			if (lossCnt_ff >= tmo) begin
				nxt_lost = 1'b1; // [R07]
			end
		end
		nxt_flashCnt = flashCnt_ff;
		nxt_flash = flash_ff;
		if (!alarm_ff) begin
			nxt_flashCnt = 9'h0;
			nxt_flash = 1'b0;
		end else if (msTick) begin
			nxt_flashCnt = flashCnt_ff + 9'h1;
			if (flashCnt_ff == `AFO_FLASH_HALF_MS - 9'h1) begin
				nxt_flashCnt = 9'h0;
				nxt_flash = ~flash_ff; // [R15]
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			msCnt_ff <= 17'h0;
			lossCnt_ff <= 16'h0;
			lost_ff <= 1'b1;
			flashCnt_ff <= 9'h0;
			flash_ff <= 1'b0;
		end else if (clkEn) begin
			msCnt_ff <= nxt_msCnt;
			lossCnt_ff <= nxt_lossCnt;
			lost_ff <= nxt_lost;
			flashCnt_ff <= nxt_flashCnt;
			flash_ff <= nxt_flash;
		end
	end

	// ****************************************
	// Configuration and value sampling
	// ****************************************
	afo_func_e func_ff, nxt_func;
	afo_dir_e dir_ff, nxt_dir;
	afo_val_t val_ff, nxt_val, act_ff, nxt_act, deact_ff, nxt_deact;
	afo_val_t lo_ff, nxt_lo, hi_ff, nxt_hi;
	logic [17:0] fLoM_ff, nxt_fLoM, fHiM_ff, nxt_fHiM;

	always_comb begin
		nxt_func = funcSel; // [R16]
		nxt_dir = dirSel;
		nxt_lo = valLo;
		nxt_hi = valHi;
		nxt_fLoM = ((freqLoHz > `AFO_FREQ_MAX_HZ) ? 18'(`AFO_FREQ_MAX_HZ) : 18'(freqLoHz))
			* `AFO_MHZ_PER_HZ;
		nxt_fHiM = ((freqHiHz > `AFO_FREQ_MAX_HZ) ? 18'(`AFO_FREQ_MAX_HZ) : 18'(freqHiHz))
			* `AFO_MHZ_PER_HZ;
		unique case (srcSel)
			AFO_SRC_POWER: begin
				nxt_val = powerVal; // [R06]
				nxt_act = powerAct;
				nxt_deact = powerDeact;
			end
			AFO_SRC_SIGNAL: begin
				nxt_val = lost_ff ? 24'sh000000 : `AFO_SIG_ONE; // [R08]
				nxt_dir = AFO_DIR_FALLING; // [R09]
				nxt_act = `AFO_SIG_HALF;
				nxt_deact = `AFO_SIG_HALF;
			end
			default: begin
				nxt_val = flowVal;
				nxt_act = flowAct;
				nxt_deact = flowDeact;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			func_ff <= AFO_FUNC_ALARM;
			dir_ff <= AFO_DIR_RISING;
			val_ff <= 24'sh000000;
			act_ff <= 24'sh000000;
			deact_ff <= 24'sh000000;
			lo_ff <= 24'sh000000;
			hi_ff <= 24'sh000000;
			fLoM_ff <= 18'h0;
			fHiM_ff <= 18'h0;
		end else if (clkEn) begin
			func_ff <= nxt_func;
			dir_ff <= nxt_dir;
			val_ff <= nxt_val;
			act_ff <= nxt_act;
			deact_ff <= nxt_deact;
			lo_ff <= nxt_lo;
			hi_ff <= nxt_hi;
			fLoM_ff <= nxt_fLoM;
			fHiM_ff <= nxt_fHiM;
		end
	end

	// ****************************************
	// Hysteresis alarm
	// ****************************************
	logic nxt_alarm, event_ff, nxt_event;

	always_comb begin
		nxt_alarm = alarm_ff; // [R17]
		if (func_ff != AFO_FUNC_ALARM) begin
			nxt_alarm = 1'b0; // [R16]
		end else if (dir_ff == AFO_DIR_RISING) begin
			if (!alarm_ff && val_ff > act_ff) begin
				nxt_alarm = 1'b1; // [R01]
			end else if (alarm_ff && val_ff < deact_ff) begin
				nxt_alarm = 1'b0; // [R02]
			end
		end else begin
			if (!alarm_ff && val_ff < act_ff) begin
				nxt_alarm = 1'b1; // [R03] [R05]
			end else if (alarm_ff && val_ff > deact_ff) begin
				nxt_alarm = 1'b0; // [R03] [R05]
			end
		end
		nxt_event = nxt_alarm & ~alarm_ff; // [R15]
	end

	always_ff @(posedge ref_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			alarm_ff <= 1'b0; // [R17]
			event_ff <= 1'b0;
		end else if (clkEn) begin
			alarm_ff <= nxt_alarm;
			event_ff <= nxt_event;
		end
	end

	// ****************************************
	// Linear frequency mapping
	// ****************************************
	afo_div_e div_ff, nxt_div;
	logic [25:0] rem_ff, nxt_rem;
	logic [42:0] quot_ff, nxt_quot;
	logic [24:0] den_ff, nxt_den;
	logic neg_ff, nxt_neg;
	logic [5:0] cnt_ff, nxt_cnt;
	logic [17:0] freq_ff, nxt_freq;
	logic signed [24:0] vd, dd;
	logic signed [18:0] fd;
	logic [24:0] vMag, dMag;
	logic [17:0] fMag;
	logic [25:0] shRem;
	logic signed [44:0] fSum;

	always_comb begin
		vd = 25'(val_ff) - 25'(lo_ff);
		dd = 25'(hi_ff) - 25'(lo_ff);
		fd = 19'(fHiM_ff) - 19'(fLoM_ff); // [R14]
		vMag = vd[24] ? 25'(-vd) : 25'(vd);
		dMag = dd[24] ? 25'(-dd) : 25'(dd);
		fMag = fd[18] ? 18'(-fd) : 18'(fd);
		shRem = {rem_ff[24:0], quot_ff[42]};
		fSum = $signed({27'h0, fLoM_ff})
			+ (neg_ff ? -$signed({2'b00, quot_ff}) : $signed({2'b00, quot_ff}));
		nxt_div = div_ff;
		nxt_rem = rem_ff;
		nxt_quot = quot_ff;
		nxt_den = den_ff;
		nxt_neg = neg_ff;
		nxt_cnt = cnt_ff;
		nxt_freq = freq_ff;
		unique case (div_ff)
			AFO_DIV_LOAD: begin
				if (dMag == 25'h0) begin
					nxt_freq = fLoM_ff;
				end else begin
					nxt_quot = 43'(vMag) * 43'(fMag); // [R10]
					nxt_rem = 26'h0;
					nxt_den = dMag;
					nxt_neg = vd[24] ^ fd[18] ^ dd[24];
					nxt_cnt = `AFO_DIV_BITS;
					nxt_div = AFO_DIV_RUN;
				end
			end
			AFO_DIV_RUN: begin
				nxt_quot = {quot_ff[41:0], 1'b0};
				nxt_rem = shRem;
				if (shRem >= {1'b0, den_ff}) begin
					nxt_rem = shRem - {1'b0, den_ff};
					nxt_quot[0] = 1'b1;
				end
				nxt_cnt = cnt_ff - 6'h1;
				if (cnt_ff == 6'h1) begin
					nxt_div = AFO_DIV_DONE;
				end
			end
			AFO_DIV_DONE: begin
				if (fSum <= 45'sh0) begin
					nxt_freq = 18'h0;
				end else if (fSum > $signed({27'h0, `AFO_FREQ_MAX_MHZ})) begin
					nxt_freq = `AFO_FREQ_MAX_MHZ; // [R10]
				end else if (fSum < $signed({27'h0, `AFO_FREQ_MIN_MHZ})) begin
					nxt_freq = `AFO_FREQ_MIN_MHZ; // [R12]
				end else begin
					nxt_freq = fSum[17:0];
				end
				nxt_div = AFO_DIV_LOAD;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			div_ff <= AFO_DIV_LOAD;
			rem_ff <= 26'h0;
			quot_ff <= 43'h0;
			den_ff <= 25'h0;
			neg_ff <= 1'b0;
			cnt_ff <= 6'h0;
			freq_ff <= 18'h0;
		end else if (clkEn) begin
			div_ff <= nxt_div;
			rem_ff <= nxt_rem;
			quot_ff <= nxt_quot;
			den_ff <= nxt_den;
			neg_ff <= nxt_neg;
			cnt_ff <= nxt_cnt;
			freq_ff <= nxt_freq;
		end
	end

	// ****************************************
	// Output switch
	// ****************************************
	logic wave;
	logic switch_ff, nxt_switch;

	afo_freq_gen u_gen (
		.clk(ref_clk),
		.rstn(rstSyncN),
		.en(clkEn),
		.freqMilliHz(freq_ff),
		.waveOut(wave)
	);

	always_comb begin
		nxt_switch = (func_ff == AFO_FUNC_ALARM) ? alarm_ff : wave; // [R16]
	end

	always_ff @(posedge ref_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			switch_ff <= 1'b0;
		end else if (clkEn) begin
			switch_ff <= nxt_switch;
		end
	end

	assign outSwitch = switch_ff;
	assign alarmActive = alarm_ff;
	assign alarmEvent = event_ff;
	assign ledFlash = flash_ff;
	assign sigLost = lost_ff;
	assign freqMilliHz = freq_ff;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstSyncN);

	sequence riseCause;
		clkEn && func_ff == AFO_FUNC_ALARM && dir_ff == AFO_DIR_RISING && !alarm_ff;
	endsequence
	sequence alarmRise;
		clkEn && !alarm_ff ##1 alarm_ff;
	endsequence

	rise_set_a: assert property (riseCause and (val_ff > act_ff) |=> alarm_ff) // [R01]
		else $error("rising alarm missed activation");
	rise_hold_a: assert property (clkEn && func_ff == AFO_FUNC_ALARM && alarm_ff // [R02]
		&& dir_ff == AFO_DIR_RISING && val_ff >= deact_ff |=> alarm_ff)
		else $error("rising alarm released too early");
	fall_set_a: assert property (clkEn && func_ff == AFO_FUNC_ALARM // [R03]
		&& dir_ff == AFO_DIR_FALLING && !alarm_ff && val_ff < act_ff |=> alarm_ff)
		else $error("falling alarm missed activation");
	signed_clear_a: assert property (clkEn && alarm_ff && dir_ff == AFO_DIR_FALLING // [R05]
		&& func_ff == AFO_FUNC_ALARM && $signed(val_ff) > $signed(deact_ff) |=> !alarm_ff)
		else $error("falling alarm not cleared on signed compare");
	hold_between_a: assert property (clkEn && func_ff == AFO_FUNC_ALARM // [R17]
		&& val_ff <= act_ff && val_ff >= deact_ff && dir_ff == AFO_DIR_RISING
		|=> alarm_ff == $past(alarm_ff))
		else $error("alarm changed between levels");
	power_src_a: assert property (clkEn && srcSel == AFO_SRC_POWER // [R06]
		|=> val_ff == $past(powerVal) && act_ff == $past(powerAct))
		else $error("power source not selected");
	loss_time_a: assert property ($rose(lost_ff) |-> $past(lossCnt_ff) >= $past(tmo)) // [R07]
		else $error("signal loss declared before timeout");
	sig_value_a: assert property (clkEn && srcSel == AFO_SRC_SIGNAL // [R08] [R09]
		|=> dir_ff == AFO_DIR_FALLING && act_ff == `AFO_SIG_HALF
		&& val_ff == ($past(lost_ff) ? 24'sh000000 : `AFO_SIG_ONE))
		else $error("signal source value or defaults wrong");
	freq_range_a: assert property (freq_ff == 18'h0 || (freq_ff >= `AFO_FREQ_MIN_MHZ // [R10] [R12]
		&& freq_ff <= `AFO_FREQ_MAX_MHZ))
		else $error("frequency outside allowed range");
	event_flag_a: assert property (alarmRise |-> event_ff) // [R15]
		else $error("alarm activation gave no status event");
	alarm_switch_a: assert property (clkEn && func_ff == AFO_FUNC_ALARM // [R16]
		|=> switch_ff == $past(alarm_ff))
		else $error("switch does not follow alarm");
endmodule : afo_channel

//--- afo_far_end.sv
// Far-side model: counting equipment wired to the output switch
`timescale 1ns/1ps
module afo_far_end (
	input logic ref_clk,
	input logic outSwitch,
	output int toggles
);
	int count_ff = 0;
	logic lastLevel = 1'b0;

	// ****************************************
	// Count every change of the switch contact
	// ****************************************
	always @(posedge ref_clk) begin
		if (outSwitch !== lastLevel) begin
			count_ff <= count_ff + 1;
		end
		lastLevel <= outSwitch;
	end

	assign toggles = count_ff;
endmodule : afo_far_end

//--- afo_channel_bench.sv
// Self-checking testbench of the alarm and frequency output channel
`timescale 1ns/1ps
module afo_channel_bench;
	import afo_pkg::*;
	localparam int MS = 10;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic clkEn = 1'b1;
	afo_func_e funcSel = AFO_FUNC_ALARM;
	afo_src_e srcSel = AFO_SRC_FLOW;
	afo_dir_e dirSel = AFO_DIR_RISING;
	afo_val_t flowVal = '0, powerVal = '0, flowAct = '0, flowDeact = '0;
	afo_val_t powerAct = '0, powerDeact = '0, valLo = '0, valHi = '0;
	logic sigBad = 1'b0;
	logic [15:0] lossTimeoutMs = 16'h0005;
	logic [7:0] freqLoHz = 8'h00, freqHiHz = 8'h00;
	logic outSwitch, alarmActive, alarmEvent, ledFlash, sigLost;
	logic [17:0] freqMilliHz;
	int toggles;
	int n_fail = 0, n_compared = 0, nEvents = 0;

	always #5 ref_clk = ~ref_clk;

	// Alarm events are counted away from the launching edge
	always @(negedge ref_clk) if (alarmEvent === 1'b1) nEvents++;

	afo_channel #(.MS_CYCLES(MS)) u_afo_channel (.ref_clk(ref_clk), .rstn(rstn), .clkEn(clkEn),
		.funcSel(funcSel), .srcSel(srcSel), .dirSel(dirSel), .flowVal(flowVal),
		.powerVal(powerVal), .flowAct(flowAct), .flowDeact(flowDeact), .powerAct(powerAct),
		.powerDeact(powerDeact), .sigBad(sigBad), .lossTimeoutMs(lossTimeoutMs),
		.freqLoHz(freqLoHz), .freqHiHz(freqHiHz), .valLo(valLo), .valHi(valHi),
		.outSwitch(outSwitch), .alarmActive(alarmActive), .alarmEvent(alarmEvent),
		.ledFlash(ledFlash), .sigLost(sigLost), .freqMilliHz(freqMilliHz));

	afo_far_end u_afo_far_end (.ref_clk(ref_clk), .outSwitch(outSwitch), .toggles(toggles));

	// ****************************************
	// Shared tasks
	// ****************************************
	task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH at %0t: %s", $time, what);
		end
	endtask : check

	task tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : tick

	// Drive the selected source, then judge alarm state and switch
	task expect_alarm(input int v, input logic exp);
		if (srcSel == AFO_SRC_POWER) powerVal = afo_val_t'(v * 256);
		else flowVal = afo_val_t'(v * 256);
		tick(4);
		check(alarmActive, exp, "alarm state");
		check(outSwitch, exp, "output switch");
	endtask : expect_alarm

	task print_verdict;
		$display("Comparisons %0d, mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : print_verdict

	// ****************************************
	// Scenarios
	// ****************************************
	task test_reset;
		check(alarmActive, 1'b0, "alarm in reset");
		check({outSwitch, alarmEvent, ledFlash}, 3'b000, "outputs in reset");
		check(sigLost, 1'b1, "signal lost in reset");
		check(freqMilliHz, 18'h00000, "frequency in reset");
		$display("test_reset done");
	endtask : test_reset

	task test_rising;
		int ev;
		ev = nEvents;
		flowAct = afo_val_t'(300 * 256);
		flowDeact = afo_val_t'(280 * 256);
		expect_alarm(300, 1'b0);
		expect_alarm(301, 1'b1);
		check(nEvents, ev + 1, "one alarm event");
		expect_alarm(290, 1'b1);
		expect_alarm(280, 1'b1);
		for (int i = 0; i < 6000 && ledFlash !== 1'b1; i++) tick(1);
		check(ledFlash, 1'b1, "indicator flashing");
		expect_alarm(279, 1'b0);
		tick(2);
		check(ledFlash, 1'b0, "indicator off");
		check(nEvents, ev + 1, "no event on release");
		$display("test_rising done");
	endtask : test_rising

	task test_falling;
		dirSel = AFO_DIR_FALLING;
		flowAct = afo_val_t'(-300 * 256);
		flowDeact = afo_val_t'(-280 * 256);
		expect_alarm(-299, 1'b0);
		clkEn = 1'b0;
		flowVal = afo_val_t'(-301 * 256);
		tick(4);
		check(alarmActive, 1'b0, "state frozen while disabled");
		clkEn = 1'b1;
		expect_alarm(-301, 1'b1);
		expect_alarm(-290, 1'b1);
		expect_alarm(-279, 1'b0);
		$display("test_falling done");
	endtask : test_falling

	task test_power;
		srcSel = AFO_SRC_POWER;
		dirSel = AFO_DIR_RISING;
		flowVal = '0;
		powerAct = afo_val_t'(20 * 256);
		powerDeact = afo_val_t'(10 * 256);
		expect_alarm(21, 1'b1);
		expect_alarm(15, 1'b1);
		expect_alarm(9, 1'b0);
		powerAct = afo_val_t'(8 * 256);
		powerDeact = afo_val_t'(6 * 256);
		expect_alarm(9, 1'b1);
		powerAct = afo_val_t'(20 * 256);
		powerDeact = afo_val_t'(10 * 256);
		expect_alarm(5, 1'b0);
		$display("test_power done");
	endtask : test_power

	// Reset in mid-run with the alarm standing
	task test_midreset;
		powerVal = afo_val_t'(21 * 256);
		tick(4);
		check(alarmActive, 1'b1, "alarm before reset");
		rstn = 1'b0;
		#1;
		check({alarmActive, outSwitch}, 2'b00, "alarm cleared by reset");
		tick(3);
		rstn = 1'b1;
		tick(2);
		check(alarmActive, 1'b0, "alarm clear after release");
		tick(4);
		check(alarmActive, 1'b1, "alarm set again");
		powerVal = '0;
		tick(4);
		check(alarmActive, 1'b0, "alarm released");
		$display("test_midreset done");
	endtask : test_midreset

	task test_signal;
		srcSel = AFO_SRC_SIGNAL;
		dirSel = AFO_DIR_RISING;
		tick(4);
		check(sigLost, 1'b0, "signal present");
		check(alarmActive, 1'b0, "no alarm while present");
		sigBad = 1'b1;
		tick(40);
		check(sigLost, 1'b0, "loss not yet declared");
		for (int i = 0; i < 40 && sigLost !== 1'b1; i++) tick(1);
		check(sigLost, 1'b1, "loss declared");
		tick(4);
		check(alarmActive, 1'b1, "alarm on loss");
		sigBad = 1'b0;
		tick(4);
		check(sigLost, 1'b0, "signal regained");
		check(alarmActive, 1'b0, "alarm cleared");
		$display("test_signal done");
	endtask : test_signal

	task test_freq;
		int t;
		srcSel = AFO_SRC_FLOW;
		funcSel = AFO_FUNC_FREQ;
		freqHiHz = 8'hc8;
		valHi = afo_val_t'(1000 * 256);
		flowVal = afo_val_t'(500 * 256);
		tick(100);
		check(freqMilliHz, 18'h186a0, "mid-range frequency");
		check(alarmActive, 1'b0, "no alarm in frequency mode");
		flowVal = afo_val_t'(2000 * 256);
		tick(100);
		check(freqMilliHz, 18'h30d40, "frequency clamped");
		flowVal = '0;
		tick(100);
		check(freqMilliHz, 18'h00000, "zero frequency");
		t = toggles;
		tick(200);
		check(outSwitch, 1'b1, "switch closed at zero");
		check(toggles, t, "switch steady at zero");
		freqHiHz = 8'h01;
		valHi = afo_val_t'(100 * 256);
		flowVal = afo_val_t'(256);
		tick(100);
		check(freqMilliHz, 18'h00011, "slowest rate raised");
		$display("test_freq done");
	endtask : test_freq

	task test_inverted;
		srcSel = AFO_SRC_SIGNAL;
		freqLoHz = 8'h64;
		freqHiHz = 8'h00;
		valLo = '0;
		valHi = 24'sh000100;
		tick(100);
		check(freqMilliHz, 18'h00000, "present gives zero");
		check(outSwitch, 1'b1, "present gives steady level");
		sigBad = 1'b1;
		tick(200);
		check(freqMilliHz, 18'h186a0, "lost gives 100 Hz");
		$display("test_inverted done");
	endtask : test_inverted

	// ****************************************
	// Main sequence and watchdog
	// ****************************************
	initial begin
		tick(10);
		test_reset();
		tick(2);
		rstn = 1'b1;
		tick(4);
		test_rising();
		test_falling();
		test_power();
		test_midreset();
		test_signal();
		test_freq();
		test_inverted();
		print_verdict();
	end

	initial begin
		repeat (30000) @(posedge ref_clk);
		n_fail++;
		$display("MISMATCH at %0t: watchdog expired", $time);
		print_verdict();
	end
endmodule : afo_channel_bench
